// File: hdl/vls_ctrl.v
// Purpose: Control logic of a four-link video crossbar switch
// Assumes: APB stands in for the serial port; pins are asynchronous
// Notes:   Every analog setting leaves on a registered output
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "vls_map.vh"

module vls_ctrl #(
   parameter PULSE_CYCLES = `VLS_TERM_PULSE_MS * `VLS_PCLK_KHZ,
   parameter CNT_W        = 22
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [2:0]  device_addr_select,
   input  wire [1:0]  pin_channel_select,
   input  wire        pin_equalizer_level,
   input  wire        pin_output_termination,
   input  wire        pin_output_enable,
   input  wire        pin_output_current,
   input  wire [1:0]  pin_preemphasis_level,
   output reg  [1:0]  hs_route_mode,
   output reg  [3:0]  hs_route_select,
   output reg  [1:0]  aux_route_mode,
   output reg  [3:0]  aux_route_select,
   output reg  [15:0] input_term_off,
   output reg  [7:0]  input_eq_high,
   output reg         output_term_on,
   output reg         output_current_high,
   output reg  [1:0]  output_preemphasis,
   output reg         output_enable,
   output reg         serial_locked
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers
// Every parallel pin and the address strap is asynchronous to pclk,
// so all of them pass two flops before any logic looks at them.
// A pin that moves mid-sample may land one cycle late; levels are
// static in use, so that skew is harmless.


   localparam PIN_W = 11;

   wire [PIN_W-1:0] pin_raw;
   reg  [PIN_W-1:0] pin_meta_q;
   reg  [PIN_W-1:0] pin_sync_q;

   assign pin_raw = {device_addr_select, pin_preemphasis_level,
                     pin_output_current, pin_output_enable,
                     pin_output_termination, pin_equalizer_level,
                     pin_channel_select};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= {PIN_W{1'b0}};
         pin_sync_q <= {PIN_W{1'b0}};
      end else begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   wire [1:0] s_ch   = pin_sync_q[1:0];
   wire       s_eq   = pin_sync_q[2];
   wire       s_oto  = pin_sync_q[3];
   wire       s_en   = pin_sync_q[4];
   wire       s_ocl  = pin_sync_q[5];
   wire [1:0] s_pe   = pin_sync_q[7:6];
   wire [2:0] s_addr = pin_sync_q[10:8];

////////////////////////////////////////////////////////////////////////
// Strap capture after reset release
// Pin levels cannot be loaded under asynchronous reset, so the
// straps are taken once the synchroniser holds valid data.
// The two output straps load the serial copies once, so a later
// lock starts from the strapped termination and current levels.
// The device address is frozen here; moving its pins afterwards
// has no effect until the next reset.


   reg [1:0] boot_cnt_q;
   reg       boot_done_q;
   reg [2:0] dev_addr_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_cnt_q  <= 2'h0;
         boot_done_q <= 1'b0;
         dev_addr_q  <= 3'h0;
      end else if (!boot_done_q) begin
         boot_cnt_q <= boot_cnt_q + 2'h1;
         if (boot_cnt_q == 2'h2) begin
            boot_done_q <= 1'b1;
            dev_addr_q  <= s_addr;
         end
      end
   end

////////////////////////////////////////////////////////////////////////
// APB decode
// Bit 11 must be clear and bits 10:8 must match the strapped
// address; anything else is answered with an error and no write.
// Accesses during the boot phase are refused the same way.


   wire       acc      = psel & penable;
   wire       dev_hit  = (paddr[10:`VLS_DEVSEL_LSB] == dev_addr_q); // see [RQ3]
   wire [7:0] ofs      = paddr[7:0];
   wire       hit_hs   = (ofs == `VLS_OFS_HS_MODE);
   wire       hit_aux  = (ofs == `VLS_OFS_AUX_MODE);
   wire       hit_pls  = (ofs == `VLS_OFS_TERM_PLS);
   wire       hit_rx   = (ofs == `VLS_OFS_RX_SET);
   wire       hit_tx   = (ofs == `VLS_OFS_TX_SET);
   wire       hit_st   = (ofs == `VLS_OFS_STATUS);
   wire       mapped   = dev_hit & paddr[11] == 1'b0 &
                         (hit_hs | hit_aux | hit_pls | hit_rx | hit_tx |
                          hit_st);
   wire       wr       = acc & pwrite & mapped & boot_done_q;

////////////////////////////////////////////////////////////////////////
// Serial configuration registers
// Reads and writes alike count as a serial event and set the lock.
// The lock only clears under reset, so pins stay ignored after it.


   reg        highspeed_output_enable_q;
   reg [1:0]  highspeed_mode_select_q;
   reg [3:0]  highspeed_channel_select_q;
   reg [1:0]  aux_sm_q;
   reg [3:0]  aux_ch_q;
   reg [15:0] pls_en_q;
   reg [7:0]  input_equalizer_level_q;
   reg        input_term_global_off_q;
   reg        output_termination_on_q;
   reg        output_current_select_q;
   reg [1:0]  output_preemphasis_level_q;
   reg        lock_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin // see [RQ4]
         highspeed_output_enable_q  <= `VLS_RST_HIGHSPEED_OUTPUT_ENABLE;
         highspeed_mode_select_q  <= `VLS_MODE_QUAD;                    // see [RQ22]
         highspeed_channel_select_q  <= `VLS_RST_CH;
         aux_sm_q <= `VLS_MODE_QUAD;
         aux_ch_q <= `VLS_RST_CH;
         pls_en_q <= `VLS_RST_PLS_EN;
         input_equalizer_level_q  <= `VLS_RST_EQ;
         input_term_global_off_q  <= `VLS_RST_TO;                       // see [RQ9]
         output_termination_on_q <= 1'b0;
         output_current_select_q <= 1'b0;
         output_preemphasis_level_q  <= `VLS_RST_PE;
         lock_q   <= 1'b0;
      end else begin
         if (boot_cnt_q == 2'h2 && !boot_done_q) begin
            output_termination_on_q <= s_oto;                          // see [RQ15]
            output_current_select_q <= s_ocl;                          // see [RQ17]
         end
         if (acc && mapped && boot_done_q)
            lock_q <= 1'b1;                     // see [RQ5] see [RQ23]
         if (wr && hit_hs) begin
            highspeed_output_enable_q <= pwdata[`VLS_HIGHSPEED_OUTPUT_ENABLE_BIT];
            highspeed_mode_select_q <= pwdata[`VLS_HIGHSPEED_MODE_SELECT_LSB +: 2];     // see [RQ21]
            highspeed_channel_select_q <= pwdata[`VLS_HIGHSPEED_CHANNEL_SELECT_LSB +: 4];
         end
         if (wr && hit_aux) begin                       // see [RQ6]
            aux_sm_q <= pwdata[`VLS_AUX_SM_LSB +: 2];
            aux_ch_q <= pwdata[`VLS_AUX_CH_LSB +: 4];
         end
         if (wr && hit_pls)
            pls_en_q <= pwdata[15:0];
         if (wr && hit_rx) begin
            input_equalizer_level_q <= pwdata[`VLS_INPUT_EQUALIZER_LEVEL_LSB +: 8];
            input_term_global_off_q <= pwdata[`VLS_INPUT_TERM_GLOBAL_OFF_BIT];
         end
         if (wr && hit_tx) begin
            output_termination_on_q <= pwdata[`VLS_OUTPUT_TERMINATION_ON_BIT];
            output_current_select_q <= pwdata[`VLS_OUTPUT_CURRENT_SELECT_BIT];
            output_preemphasis_level_q  <= pwdata[`VLS_OUTPUT_PREEMPHASIS_LEVEL_LSB +: 2];
         end
      end
   end

////////////////////////////////////////////////////////////////////////
// Effective settings: pins until locked, registers after
// While unlocked only quad routing exists and the one pin select
// drives both the high speed and auxiliary paths.


   reg [1:0] hs_mode_d;
   reg [3:0] hs_sel_d;
   reg [1:0] aux_mode_d;
   reg [3:0] aux_sel_d;
   reg [7:0] eq_d;
   reg       oto_d;
   reg       ocl_d;
   reg [1:0] pe_d;
   reg       en_d;

   always @* begin
      if (lock_q) begin
         hs_mode_d  = highspeed_mode_select_q;                 // see [RQ2] see [RQ6]
         hs_sel_d   = highspeed_channel_select_q;          // see [RQ24] see [RQ25]
         aux_mode_d = aux_sm_q;
         aux_sel_d  = aux_ch_q;
         eq_d       = input_equalizer_level_q;                          // see [RQ11]
         oto_d      = output_termination_on_q;                         // see [RQ13]
         ocl_d      = output_current_select_q;                         // see [RQ16]
         pe_d       = output_preemphasis_level_q;                          // see [RQ20]
         en_d       = highspeed_output_enable_q;                          // see [RQ14]
      end else begin
         hs_mode_d  = `VLS_MODE_QUAD;                   // see [RQ7]
         hs_sel_d   = {2'h0, s_ch};             // see [RQ1] see [RQ26]
         aux_mode_d = `VLS_MODE_QUAD;
         aux_sel_d  = {2'h0, s_ch};                     // see [RQ7]
         eq_d       = {8{s_eq}};                        // see [RQ12]
         oto_d      = s_oto;                            // see [RQ13]
         ocl_d      = s_ocl;                            // see [RQ16]
         pe_d       = s_pe;                             // see [RQ20]
         en_d       = s_en;                             // see [RQ14]
      end
   end

////////////////////////////////////////////////////////////////////////
// Termination disconnect pulse after a source switch
// One shared timer serves all sixteen inputs; a fresh switch while
// the pulse runs restarts it, so the off time never cuts short.
// Trade-off: one timer instead of sixteen saves area, at the cost
// that all enabled inputs share a single off window.
// The first lock also counts as a switch, since routing may move
// from the pin selection to the register selection.


   reg [CNT_W-1:0] pls_cnt_q;
   wire            pls_run  = (pls_cnt_q != {CNT_W{1'b0}});
   wire            src_sw   = lock_q & boot_done_q &
                              ((hs_mode_d != hs_route_mode) |
                               (hs_sel_d != hs_route_select));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pls_cnt_q <= {CNT_W{1'b0}};
      else if (src_sw)
         pls_cnt_q <= PULSE_CYCLES[CNT_W-1:0];          // see [RQ8]
      else if (pls_run)
         pls_cnt_q <= pls_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
   end

   wire [15:0] term_off_d;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_term
         // Pins never disconnect a termination
         assign term_off_d[gi] = lock_q &                  // see [RQ10]
                                 (input_term_global_off_q |                 // see [RQ9]
                                  (pls_en_q[gi] & (pls_run | src_sw)));
      end
   endgenerate

////////////////////////////////////////////////////////////////////////
// Registered outputs
// Outputs hold their reset levels through the boot phase so that
// no half-synchronised pin value ever reaches the analog side.


   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_route_mode       <= `VLS_MODE_QUAD;
         hs_route_select     <= `VLS_RST_CH;
         aux_route_mode      <= `VLS_MODE_QUAD;
         aux_route_select    <= `VLS_RST_CH;
         input_term_off      <= 16'h0000;
         input_eq_high       <= `VLS_RST_EQ;
         output_term_on      <= 1'b0;
         output_current_high <= 1'b0;
         output_preemphasis  <= `VLS_RST_PE;
         output_enable       <= 1'b0;
         serial_locked       <= 1'b0;
      end else if (boot_done_q) begin
         hs_route_mode       <= hs_mode_d;
         hs_route_select     <= hs_sel_d;
         aux_route_mode      <= aux_mode_d;
         aux_route_select    <= aux_sel_d;
         input_term_off      <= term_off_d;
         input_eq_high       <= eq_d;
         output_term_on      <= oto_d;
         output_current_high <= ocl_d;
         output_preemphasis  <= pe_d;
         output_enable       <= en_d;
         serial_locked       <= lock_q;
      end
   end

////////////////////////////////////////////////////////////////////////
// APB answer: zero wait states, error on unmapped or foreign address
// pready rises in the access cycle after every setup; no wait
// states are ever inserted, so a master never stalls here.
// prdata is forced to zero outside a read access.


   reg [31:0] rd_d;

   always @* begin
      rd_d = 32'h00000000;
      if (hit_hs)
         rd_d = {25'h0, highspeed_channel_select_q, highspeed_mode_select_q, highspeed_output_enable_q};
      else if (hit_aux)
         rd_d = {26'h0, aux_ch_q, aux_sm_q};
      else if (hit_pls)
         rd_d = {16'h0, pls_en_q};
      else if (hit_rx)
         rd_d = {23'h0, input_term_global_off_q, input_equalizer_level_q};
      else if (hit_tx)
         rd_d = {28'h0, output_preemphasis_level_q, output_current_select_q, output_termination_on_q};
      else if (hit_st)
         rd_d = {26'h0, dev_addr_q, pls_run, boot_done_q, lock_q};
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~(mapped & boot_done_q);
         if (psel && !penable && !pwrite && mapped)
            prdata <= rd_d;
         else
            prdata <= 32'h00000000;
      end
   end

endmodule // vls_ctrl

// File: hdl/vls_map.vh
// Purpose: Constants of the video link switch control block
// Assumes: APB slave, 32-bit data, 40 MHz pclk
// Notes:   Offsets are byte addresses, one register per aligned word
//
// Functional notes
// [RQ1] Route one of four links to output
// [RQ2] Quad, dual and single routing modes
// [RQ3] Answer one of eight selectable device addresses
// [RQ4] Reset restores every control register default
// [RQ5] Serial access overrides pins until reset
// [RQ6] Serial: all modes, aux mode independent
// [RQ7] Parallel: quad only, one select drives both
// [RQ8] Enabled inputs drop termination 100 ms
// [RQ9] Global off bit; termination on by default
// [RQ10] Parallel: terminations always connected
// [RQ11] Two boost levels, per-channel serial bits
// [RQ12] Parallel: one pin sets all eight
// [RQ13] Output termination from bit or pin
// [RQ14] Output enable bit or pin tristates outputs
// [RQ15] Reset takes output termination from pin
// [RQ16] Output current two levels, bit or pin
// [RQ17] Reset takes output current from pin
// [RQ18] Host picks current to suit termination
// [RQ19] Host disables outputs without any termination
// [RQ20] Four pre-emphasis levels, field or pins
// [RQ21] Routing mode set only over serial port
// [RQ22] Quad default; select from field or pins
// [RQ23] Follow pins until first serial event
// [RQ24] Dual: both selectors share one select
// [RQ25] Single: one of sixteen to all outputs
// [RQ26] Parallel pins applied continuously, no reset
`ifndef VLS_MAP_VH
`define VLS_MAP_VH

`define VLS_OFS_HS_MODE   12'h000
`define VLS_OFS_AUX_MODE  12'h004
`define VLS_OFS_TERM_PLS  12'h008
`define VLS_OFS_RX_SET    12'h00C
`define VLS_OFS_TX_SET    12'h010
`define VLS_OFS_STATUS    12'h014
`define VLS_DEVSEL_LSB    8

`define VLS_HIGHSPEED_OUTPUT_ENABLE_BIT     0
`define VLS_HIGHSPEED_MODE_SELECT_LSB     1
`define VLS_HIGHSPEED_CHANNEL_SELECT_LSB     3
`define VLS_AUX_SM_LSB    0
`define VLS_AUX_CH_LSB    2
`define VLS_INPUT_EQUALIZER_LEVEL_LSB     0
`define VLS_INPUT_TERM_GLOBAL_OFF_BIT     8
`define VLS_OUTPUT_TERMINATION_ON_BIT    0
`define VLS_OUTPUT_CURRENT_SELECT_BIT    1
`define VLS_OUTPUT_PREEMPHASIS_LEVEL_LSB     2

`define VLS_MODE_QUAD     2'h0
`define VLS_MODE_DUAL     2'h1
`define VLS_MODE_SINGLE   2'h2

`define VLS_RST_HIGHSPEED_OUTPUT_ENABLE     1'h1
`define VLS_RST_CH        4'h0
`define VLS_RST_PLS_EN    16'h0000
`define VLS_RST_EQ        8'h00
`define VLS_RST_TO        1'h0
`define VLS_RST_PE        2'h0

`define VLS_TERM_PULSE_MS 100
`define VLS_PCLK_KHZ      40000

`endif

// File: bench/vls_ctrl_sva.sv
// Purpose: Port checker for the video link switch control
// Assumes: Zero wait APB slave, pins pass two sync flops
// Notes:   Bound to the design from the bench top
`timescale 1ns/100ps
module vls_ctrl_sva (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [1:0]  pin_preemphasis_level,
   input wire logic [1:0]  hs_route_mode,
   input wire logic [3:0]  hs_route_select,
   input wire logic [1:0]  aux_route_mode,
   input wire logic [3:0]  aux_route_select,
   input wire logic [15:0] input_term_off,
   input wire logic [7:0]  input_eq_high,
   input wire logic [1:0]  output_preemphasis,
   input wire logic        serial_locked
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////////
chk_ready_setup : assert property (
   psel && !penable |=> pready) else $error("ready missing after setup");
chk_ready_single : assert property (
   pready |=> !pready) else $error("ready held too long");
chk_err_ready : assert property (
   pslverr |-> pready) else $error("error without ready");
chk_rdata_idle : assert property (
   !pready |-> prdata == 32'h0) else $error("read data outside access");
chk_lock_sticky : assert property (
   serial_locked |=> serial_locked) else $error("lock dropped");
chk_par_quad : assert property (
   !serial_locked |-> hs_route_mode == 2'h0 && aux_route_mode == 2'h0)
   else $error("non quad mode from pins");
chk_par_select : assert property (
   !serial_locked |-> hs_route_select == aux_route_select)
   else $error("selects differ from pins");
chk_par_term : assert property (
   !serial_locked |-> input_term_off == 16'h0)
   else $error("termination cut from pins");
chk_par_eq : assert property (
   !serial_locked |-> input_eq_high inside {8'h00, 8'hFF})
   else $error("equalizer not global");
// Pins must have settled through sync and boot before the compare;
// an attempt may start at the release edge, three edges before boot
chk_pin_follow : assert property (
   (!serial_locked && !psel && $stable(pin_preemphasis_level))[*7]
   |-> output_preemphasis == pin_preemphasis_level)
   else $error("pre-emphasis not following pins");
endmodule // vls_ctrl_sva

// File: bench/vls_host.sv
// Purpose: Host model driving the parallel control pins
// Assumes: Pins change just after a clock edge
// Notes:   External termination present unless EXT_TERM is 0
`timescale 1ns/100ps
module vls_host #(parameter EXT_TERM = 1) (
   input  wire logic       pclk,
   input  wire logic [6:0] cfg,
   output logic      [1:0] pin_channel_select = 2'h0,
   output logic            pin_equalizer_level = 1'b0,
   output logic            pin_output_termination = 1'b0,
   output logic            pin_output_current = 1'b0,
   output logic            pin_output_enable = 1'b0,
   output logic      [1:0] pin_preemphasis_level = 2'h0
);
always @(posedge pclk) begin
   pin_channel_select     <= cfg[1:0];
   pin_equalizer_level    <= cfg[2];
   pin_output_termination <= cfg[3];
   pin_output_current     <= cfg[3];
   // Never enable outputs with no termination at all
   pin_output_enable <= cfg[4] & (cfg[3] | EXT_TERM[0]);
   pin_preemphasis_level  <= cfg[6:5];
end
endmodule // vls_host

// File: bench/video_link_switch_control_test.sv
// Purpose: Self-checking bench for the video link switch control
// Assumes: Pulse timer shortened to PLS cycles, strap address 5
// Notes:   Model mirrors registers and pins, compared when settled
`timescale 1ns/100ps
module video_link_switch_control_test;
localparam PLS = 20;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, rg [0:4];
logic        pready, pslverr, err, lk, serial_locked;
logic [6:0]  cfg = 7'h00;
logic [1:0]  pch, ppe, hs_route_mode, aux_route_mode, output_preemphasis;
logic        peq, poto, pen, pocl, output_term_on;
logic        output_current_high, output_enable;
logic [3:0]  hs_route_select, aux_route_select;
logic [15:0] input_term_off;
logic [7:0]  input_eq_high;
integer      error_cnt = 0, n_tests = 0, seed = 32'h0182694f, i;
////////////////////////////////////////////////////////////////////////////
vls_host host (.pclk(pclk), .cfg(cfg), .pin_channel_select(pch),
   .pin_equalizer_level(peq), .pin_output_termination(poto),
   .pin_output_current(pocl), .pin_output_enable(pen),
   .pin_preemphasis_level(ppe));
vls_ctrl #(.PULSE_CYCLES(PLS), .CNT_W(22)) dut (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .device_addr_select(3'h5),
   .pin_channel_select(pch), .pin_equalizer_level(peq),
   .pin_output_termination(poto), .pin_output_enable(pen),
   .pin_output_current(pocl), .pin_preemphasis_level(ppe),
   .hs_route_mode(hs_route_mode), .hs_route_select(hs_route_select),
   .aux_route_mode(aux_route_mode), .aux_route_select(aux_route_select),
   .input_term_off(input_term_off), .input_eq_high(input_eq_high),
   .output_term_on(output_term_on), .output_enable(output_enable),
   .output_current_high(output_current_high),
   .output_preemphasis(output_preemphasis),
   .serial_locked(serial_locked));
initial forever #12.5 pclk = ~pclk;
initial begin
   repeat (20000) @(posedge pclk);
   error_cnt++;
   stop_test;
end
////////////////////////////////////////////////////////////////////////////
task stop_test;
   if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
   else $display("Some tests failed");
   $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
   n_tests++;
   if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
   end
endtask
task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
   integer n;
   logic   e;
   @(posedge pclk);
   psel <= 1;
   penable <= 0;
   paddr <= a;
   pwrite <= w;
   pwdata <= d;
   @(posedge pclk);
   penable <= 1;
   n = 0;
   do begin
      @(posedge pclk);
      n++;
   end while (pready !== 1'b1 && n < 16);
   if (n >= 16) begin
      error_cnt++;
      stop_test;
   end
   rd = prdata;
   err = pslverr;
   psel <= 0;
   penable <= 0;
   e = a[11] | (a[10:8] != 3'h5) | (a[7:0] > 8'h14);
   chk(err, e);
   if (!e) lk = 1;
   if (!e && w && a[7:0] < 8'h14) rg[a[4:2]] = d;
endtask
task cmp_all;
   logic [24:0] e;
   e = lk ? {rg[0][2:1], rg[0][6:3], rg[1][1:0], rg[1][5:2], rg[3][7:0],
             rg[4][0], rg[4][1], rg[4][3:2], rg[0][0]}
          : {4'h0, pch, 4'h0, pch, {8{peq}}, poto, pocl, ppe, pen};
   chk({hs_route_mode, hs_route_select, aux_route_mode,
        aux_route_select, input_eq_high, output_term_on,
        output_current_high, output_preemphasis,
        output_enable}, e);
   chk(input_term_off, (lk && rg[3][8]) ? 16'hFFFF : 16'h0);
   chk(serial_locked, lk);
endtask
task do_reset;
   presetn <= 0;
   repeat (12) @(posedge pclk);
   presetn <= 1;
   lk = 0;
   rg[0] = 32'h1;
   rg[1] = 32'h0;
   rg[2] = 32'h0;
   rg[3] = 32'h0;
   rg[4] = {30'h0, pocl, poto};
   repeat (6) @(posedge pclk);
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
   do_reset;
   cmp_all;
   for (i = 0; i < 6; i++) begin
      cfg <= $random(seed);
      repeat (6) @(posedge pclk);
      cmp_all;
   end
   apb(12'h200, 1, 32'h4);
   repeat (3) @(posedge pclk);
   cmp_all;
   for (i = 0; i < 3; i++) begin
      apb(12'h500, 1, ($random(seed) & 32'h79) | (i << 1));
      apb(12'h504, 1, ($random(seed) & 32'h3C) | ((i + 1) % 3));
      apb(12'h500, 0, 32'h0);
      chk(rd[6:0], rg[0][6:0]);
      repeat (3) @(posedge pclk);
      cmp_all;
   end
   cfg <= $random(seed);
   apb(12'h50C, 1, $random(seed) & 32'hFF);
   apb(12'h510, 1, $random(seed) & 32'hF);
   repeat (6) @(posedge pclk);
   cmp_all;
   apb(12'h514, 0, 32'h0);
   chk({rd[5:3], rd[1:0]}, 5'h17);
   apb(12'h518, 0, 32'h0);
   apb(12'hD00, 0, 32'h0);
   apb(12'h508, 1, 32'hA5C3);
   repeat (PLS + 4) @(posedge pclk);
   apb(12'h500, 1, rg[0] ^ 32'h8);
   repeat (PLS - 2) @(posedge pclk);
   chk(input_term_off, 16'hA5C3);
   repeat (8) @(posedge pclk);
   chk(input_term_off, 16'h0);
   apb(12'h50C, 1, 32'h100);
   repeat (3) @(posedge pclk);
   cmp_all;
   do_reset;
   cmp_all;
   stop_test;
end
endmodule // video_link_switch_control_test
bind vls_ctrl vls_ctrl_sva chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_preemphasis_level(pin_preemphasis_level),
   .hs_route_mode(hs_route_mode), .hs_route_select(hs_route_select),
   .aux_route_mode(aux_route_mode), .aux_route_select(aux_route_select),
   .input_term_off(input_term_off), .input_eq_high(input_eq_high),
   .output_preemphasis(output_preemphasis),
   .serial_locked(serial_locked));
